// >>> cpc_defines.svh
// Constants of the codec power control and status block.
// Assumes inclusion by bare name from the package and the power status module.
`ifndef CPC_DEFINES_SVH
`define CPC_DEFINES_SVH

// Register offsets on the control port
`define CPC_ADDR_POWER_CONFIGURATION      8'h78
`define CPC_ADDR_CHANNEL_POWER_STATUS     8'h79
`define CPC_ADDR_DEVICE_MODE_FAULT_STATUS 8'h7a

// Reset values
`define CPC_RESET_POWER_CONFIGURATION      8'h00
`define CPC_RESET_CHANNEL_POWER_STATUS     8'h00
`define CPC_RESET_DEVICE_MODE_FAULT_STATUS 8'h80

// Power configuration field positions
`define CPC_BIT_RECORD_MASTER_POWER     7
`define CPC_BIT_PLAYBACK_MASTER_POWER   6
`define CPC_BIT_MIC_SUPPLY_POWER        5
`define CPC_BIT_ULTRASOUND_DETECT       3
`define CPC_BIT_VOICE_DETECT            2
`define CPC_BIT_ULTRASOUND_GEN          1
`define CPC_CONFIG_WRITABLE_MASK        8'hee

// Mode status codes
`define CPC_MODE_SLEEP  3'h4
`define CPC_MODE_IDLE   3'h6
`define CPC_MODE_ACTIVE 3'h7

`endif

// >>> cpc_pkg.sv
// Types of the codec power control and status block.
// Assumes cpc_defines.svh is on the include path.
`include "cpc_defines.svh"

package cpc_pkg;

  // Device mode as read in the mode status field
  typedef enum logic [2:0]
  {
    cpc_mode_sleep  = 3'b100,
    cpc_mode_idle   = 3'b110,
    cpc_mode_active = 3'b111
  } cpc_mode_type;

  // Power configuration register layout
  typedef struct packed
  {
    logic record_master_power;
    logic playback_master_power;
    logic mic_supply_power;
    logic reserved_4;
    logic ultrasound_detect_enable;
    logic voice_detect_enable;
    logic ultrasound_gen_enable;
    logic reserved_0;
  } cpc_config_type;

  // Mode and fault status register layout
  typedef struct packed
  {
    cpc_mode_type device_mode_state;
    logic         loop_running_flag;
    logic         mic_supply_on_flag;
    logic         reserved_2;
    logic         input_fault_shutdown_flag;
    logic         bias_fault_shutdown_flag;
  } cpc_mode_status_type;

  // Whole state of the top module
  typedef struct packed
  {
    cpc_config_type      config_reg;
    logic [7:0]          channel_status;
    cpc_mode_status_type mode_status;
    logic [7:0]          read_data;
    logic                read_valid;
    logic [3:0]          input_fault_meta;
    logic [3:0]          input_fault_sync;
    logic                bias_fault_meta;
    logic                bias_fault_sync;
  } cpc_state_type;

endpackage : cpc_pkg

// >>> cpc_channel_gate.sv
// Per-channel power gate for one path (record or playback).
// Assumes synchronised fault inputs on the same clock; purely combinational.
`timescale 1ns/1ps
`default_nettype none

module cpc_channel_gate
  import cpc_pkg::*;
#(
  parameter int CHANNELS = 4
)
(
  input  wire logic                master_power,
  input  wire logic [CHANNELS-1:0] channel_enable,
  input  wire logic [CHANNELS-1:0] channel_fault,
  output var  logic [CHANNELS-1:0] channel_powered
);

  if (CHANNELS < 1 || CHANNELS > 8)
  begin : g_bad_channels
    $error("cpc_channel_gate: CHANNELS must be 1 to 8");
  end

  // One gate per channel: master, own enable, no fault
  for (genvar ch = 0; ch < CHANNELS; ch++)
  begin : g_channel
    assign channel_powered[ch] = master_power & channel_enable[ch] & ~channel_fault[ch];
  end

endmodule : cpc_channel_gate

`default_nettype wire

// >>> cpc_power_status.sv
// Codec power configuration register and two live status registers.
// Assumes a same-clock register port from the control interface logic,
// the channel enable bits from the separate channel enable register,
// and asynchronous fault levels from the analog fault detectors.
// Status lags its cause by one cycle, fault bits by two more for sync.
// A bias fault overrides every record channel; playback has no fault path.
// Writes to status offsets are dropped silently, with no error answer.
`timescale 1ns/1ps
`default_nettype none

`include "cpc_defines.svh"

module cpc_power_status
  import cpc_pkg::*;
#(
  parameter int CHANNELS = 4
)
(
  input  wire logic                  i_clock,
  input  wire logic                  i_reset,
  input  wire logic                  i_write,
  input  wire logic                  i_read,
  input  wire logic [7:0]            i_address,
  input  wire logic [7:0]            i_write_data,
  input  wire logic [CHANNELS-1:0]   i_record_channel_enable,
  input  wire logic [CHANNELS-1:0]   i_playback_channel_enable,
  input  wire logic                  i_loop_enabled,
  input  wire logic                  i_sleep_mode,
  input  wire logic [CHANNELS-1:0]   i_input_fault,
  input  wire logic                  i_bias_fault,
  output var  logic [7:0]            o_read_data,
  output var  logic                  o_read_valid,
  output var  logic [CHANNELS-1:0]   o_record_powered,
  output var  logic [CHANNELS-1:0]   o_playback_powered,
  output var  logic                  o_mic_supply_power,
  output var  logic                  o_ultrasound_detect_enable,
  output var  logic                  o_voice_detect_enable,
  output var  logic                  o_ultrasound_gen_enable
);

  if (CHANNELS != 4)
  begin : g_bad_channels
    $error("cpc_power_status: status layout holds exactly 4 channels per path");
  end

  cpc_state_type       state;
  cpc_state_type       next_state;
  logic [3:0]          record_fault;
  logic [3:0]          record_powered;
  logic [3:0]          playback_powered;

  // Reset image: register resets, empty read path, quiet fault syncs
  localparam cpc_state_type reset_state = cpc_state_type'({
    `CPC_RESET_POWER_CONFIGURATION,       // Configuration register
    `CPC_RESET_CHANNEL_POWER_STATUS,      // Channel power status
    `CPC_RESET_DEVICE_MODE_FAULT_STATUS,  // Mode and fault status
    8'h00,                                // Read data
    1'b0,                                 // Read valid
    4'h0,                                 // Input fault first stage
    4'h0,                                 // Input fault second stage
    1'b0,                                 // Bias fault first stage
    1'b0                                  // Bias fault second stage
  });

  //////////////////////////////////////////////////////////////////////////////
  // Channel gating

  // A bias fault shuts every record channel; an input fault only its own
  assign record_fault = state.input_fault_sync | {4{state.bias_fault_sync}};

  // Record path gated by master, enable and faults
  cpc_channel_gate #(
    .CHANNELS (4)
  ) u_record_gate (
    .master_power    (state.config_reg.record_master_power),
    .channel_enable  (i_record_channel_enable),
    .channel_fault   (record_fault),
    .channel_powered (record_powered)
  );

  // Playback path gated by master and enable only
  cpc_channel_gate #(
    .CHANNELS (4)
  ) u_playback_gate (
    .master_power    (state.config_reg.playback_master_power),
    .channel_enable  (i_playback_channel_enable),
    .channel_fault   (4'h0),
    .channel_powered (playback_powered)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  // Register writes, live status capture, read answer, fault sync
  always_comb
  begin
    next_state = state;

    // Fault levels pass two flip-flops before use
    next_state.input_fault_meta = i_input_fault;
    next_state.input_fault_sync = state.input_fault_meta;
    next_state.bias_fault_meta  = i_bias_fault;
    next_state.bias_fault_sync  = state.bias_fault_meta;

    // Only the configuration register takes writes
    if (i_write && i_address == `CPC_ADDR_POWER_CONFIGURATION)
    begin
      next_state.config_reg = cpc_config_type'(i_write_data & `CPC_CONFIG_WRITABLE_MASK);
    end

    // Status mirrors live channel power; writes have no path here
    next_state.channel_status = {record_powered[0], record_powered[1],
                                 record_powered[2], record_powered[3],
                                 playback_powered[0], playback_powered[1],
                                 playback_powered[2], playback_powered[3]};

    // Device mode from sleep request and any powered channel
    if (i_sleep_mode)
    begin
      next_state.mode_status.device_mode_state = cpc_mode_sleep;
    end
    else if (|{record_powered, playback_powered})
    begin
      next_state.mode_status.device_mode_state = cpc_mode_active;
    end
    else
    begin
      next_state.mode_status.device_mode_state = cpc_mode_idle;
    end
    next_state.mode_status.loop_running_flag  = i_loop_enabled;
    next_state.mode_status.mic_supply_on_flag = state.config_reg.mic_supply_power;
    next_state.mode_status.reserved_2         = 1'b0;
    next_state.mode_status.input_fault_shutdown_flag =
      |(state.input_fault_sync & i_record_channel_enable)
      & state.config_reg.record_master_power;
    next_state.mode_status.bias_fault_shutdown_flag =
      state.bias_fault_sync & state.config_reg.record_master_power;

    // Read answer one cycle after the strobe; unmapped reads zero
    next_state.read_valid = i_read;
    if (i_read)
    begin
      unique case (i_address)
        `CPC_ADDR_POWER_CONFIGURATION:      next_state.read_data = state.config_reg;
        `CPC_ADDR_CHANNEL_POWER_STATUS:     next_state.read_data = state.channel_status;
        `CPC_ADDR_DEVICE_MODE_FAULT_STATUS: next_state.read_data = state.mode_status;
        default:                            next_state.read_data = 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register

  // Synchronous reset to documented reset values
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      // One constant image, so no field is left stale by a partial reset
      state <= reset_state;
    end
    else
    begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Register answers and power controls straight from flip-flops
  assign o_read_data                = state.read_data;
  assign o_read_valid               = state.read_valid;
  assign o_record_powered           = {state.channel_status[4], state.channel_status[5],
                                       state.channel_status[6], state.channel_status[7]};
  assign o_playback_powered         = {state.channel_status[0], state.channel_status[1],
                                       state.channel_status[2], state.channel_status[3]};
  assign o_mic_supply_power         = state.config_reg.mic_supply_power;
  assign o_ultrasound_detect_enable = state.config_reg.ultrasound_detect_enable;
  assign o_voice_detect_enable      = state.config_reg.voice_detect_enable;
  assign o_ultrasound_gen_enable    = state.config_reg.ultrasound_gen_enable;

endmodule : cpc_power_status

`default_nettype wire

// >>> cpc_power_status_monitor.sv
// Concurrent checks on the ports of the power control and status block.
// Assumes four channels and one clock domain with a synchronous reset.
`timescale 1ns/1ps
`default_nettype none

module cpc_power_status_checker
  import cpc_pkg::*;
#(
  parameter int CHANNELS = 4
)
(
  input wire logic                i_clock,
  input wire logic                i_reset,
  input wire logic                i_write,
  input wire logic                i_read,
  input wire logic [7:0]          i_address,
  input wire logic [7:0]          i_write_data,
  input wire logic [CHANNELS-1:0] i_record_channel_enable,
  input wire logic                o_read_valid,
  input wire logic [CHANNELS-1:0] o_record_powered,
  input wire logic [CHANNELS-1:0] o_playback_powered,
  input wire logic                o_mic_supply_power,
  input wire logic                o_ultrasound_detect_enable,
  input wire logic                o_voice_detect_enable,
  input wire logic                o_ultrasound_gen_enable
);
  logic cfg_wr;

  // Write strobe aimed at the configuration register
  assign cfg_wr = i_write && (i_address == 8'h78);

  default clocking @(posedge i_clock);
  endclocking
  default disable iff (i_reset);

  ////////////////////////////////////////////////////////////////////////////
  mic_supply_a: assert property (cfg_wr |=> o_mic_supply_power == $past(i_write_data[5]))
    else $error("mic supply power does not follow config");
  ultra_detect_a: assert property (cfg_wr |=> o_ultrasound_detect_enable == $past(i_write_data[3]))
    else $error("ultrasound detect enable does not follow config");
  voice_detect_a: assert property (cfg_wr |=> o_voice_detect_enable == $past(i_write_data[2]))
    else $error("voice detect enable does not follow config");
  ultra_gen_a: assert property (cfg_wr |=> o_ultrasound_gen_enable == $past(i_write_data[1]))
    else $error("second ultrasound enable does not follow config");
  record_off_a: assert property (cfg_wr && !i_write_data[7] ##1 !cfg_wr |=> o_record_powered == '0)
    else $error("record channel powered with master off");
  playback_off_a: assert property (cfg_wr && !i_write_data[6] ##1 !cfg_wr |=> o_playback_powered == '0)
    else $error("playback channel powered with master off");
  record_enabled_a: assert property ((o_record_powered & ~$past(i_record_channel_enable)) == '0)
    else $error("disabled record channel powered");
  read_answer_a: assert property (i_read |=> o_read_valid)
    else $error("read not answered one cycle later");
endmodule : cpc_power_status_checker

bind cpc_power_status cpc_power_status_checker #(.CHANNELS(CHANNELS)) u_cpc_power_status_checker (.*);

`default_nettype wire

// >>> tb.sv
// Self-checking bench for the power control and status block.
// Assumes the package and design are compiled first; drives every port itself.
`timescale 1ns/1ps
`default_nettype none

module tb import cpc_pkg::*;;
  logic       i_clock = 1'b0;
  logic       i_reset = 1'b1;
  logic       i_write = 1'b0;
  logic       i_read = 1'b0;
  logic [7:0] i_address = 8'h00;
  logic [7:0] i_write_data = 8'h00;
  logic [3:0] i_record_channel_enable = 4'h0;
  logic [3:0] i_playback_channel_enable = 4'h0;
  logic       i_loop_enabled = 1'b0;
  logic       i_sleep_mode = 1'b1;
  logic [3:0] i_input_fault = 4'h0;
  logic       i_bias_fault = 1'b0;
  logic [7:0] o_read_data;
  logic       o_read_valid;
  logic [3:0] o_record_powered;
  logic [3:0] o_playback_powered;
  logic       o_mic_supply_power;
  logic       o_ultrasound_detect_enable;
  logic       o_voice_detect_enable;
  logic       o_ultrasound_gen_enable;
  int         n_fail = 0;
  int         total_checks = 0;

  cpc_power_status u_cpc_power_status (.*);

  // 250 MHz clock
  always #2 i_clock = ~i_clock;

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk

  // Register write, one idle cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_write <= 1'b1;
    i_address <= a;
    i_write_data <= d;
    @(posedge i_clock);
    i_write <= 1'b0;
    @(posedge i_clock);
  endtask : wr

  // Register read and compare, bounded wait for the answer
  task automatic rc(input string name, input logic [7:0] a, input logic [7:0] exp);
    int n;
    i_read <= 1'b1;
    i_address <= a;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1;
    for (n = 0; n < 4 && o_read_valid !== 1'b1; n++)
    begin
      @(posedge i_clock);
      #1;
    end
    if (n == 4)
    begin
      n_fail++;
      give_verdict();
    end
    chk(name, exp, o_read_data);
    @(posedge i_clock);
  endtask : rc

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    rc("config", 8'h78, 8'h00);
    rc("status0", 8'h79, 8'h00);
    rc("status1", 8'h7a, 8'h80);
    rc("unmapped", 8'h55, 8'h00);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_config;
    logic [7:0] d[4] = '{8'hff, 8'h0a, 8'h24, 8'h00};
    logic [7:0] c[4] = '{8'hee, 8'h0a, 8'h24, 8'h00};
    logic [7:0] f[4] = '{8'h0f, 8'h05, 8'h0a, 8'h00};
    logic [7:0] en;
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h78, d[k]);
      rc("config", 8'h78, c[k]);
      en = {4'h0, o_mic_supply_power, o_ultrasound_detect_enable, o_voice_detect_enable,
            o_ultrasound_gen_enable};
      chk("enables", f[k], en);
    end
    $display("test_config done");
  endtask : test_config

  task automatic test_power;
    logic [7:0] c[4] = '{8'he0, 8'h80, 8'h40, 8'h00};
    logic [7:0] s0[4] = '{8'h56, 8'h50, 8'h06, 8'h00};
    logic [7:0] s1[4] = '{8'hf8, 8'hf0, 8'hf0, 8'hd0};
    logic [7:0] p[4] = '{8'ha6, 8'ha0, 8'h06, 8'h00};
    i_record_channel_enable <= 4'b1010;
    i_playback_channel_enable <= 4'b0110;
    i_loop_enabled <= 1'b1;
    i_sleep_mode <= 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h78, c[k]);
      rc("status0", 8'h79, s0[k]);
      rc("status1", 8'h7a, s1[k]);
      chk("powered", p[k], {o_record_powered, o_playback_powered});
    end
    wr(8'h79, 8'hff);
    wr(8'h7a, 8'h00);
    rc("status0", 8'h79, 8'h00);
    rc("status1", 8'h7a, 8'hd0);
    i_sleep_mode <= 1'b1;
    @(posedge i_clock);
    rc("status1", 8'h7a, 8'h90);
    i_loop_enabled <= 1'b0;
    @(posedge i_clock);
    rc("status1", 8'h7a, 8'h80);
    i_sleep_mode <= 1'b0;
    $display("test_power done");
  endtask : test_power

  task automatic test_fault;
    wr(8'h78, 8'h80);
    i_input_fault <= 4'b1000;
    repeat (4) @(posedge i_clock);
    rc("status1", 8'h7a, 8'he2);
    chk("powered", 8'h20, {o_record_powered, o_playback_powered});
    i_bias_fault <= 1'b1;
    repeat (4) @(posedge i_clock);
    rc("status1", 8'h7a, 8'hc3);
    chk("powered", 8'h00, {o_record_powered, o_playback_powered});
    i_input_fault <= 4'h0;
    i_bias_fault <= 1'b0;
    repeat (4) @(posedge i_clock);
    rc("status1", 8'h7a, 8'he0);
    $display("test_fault done");
  endtask : test_fault

  ////////////////////////////////////////////////////////////////////////////
  // Reset for 16 cycles, then the scenarios
  initial
  begin
    repeat (16) @(posedge i_clock);
    i_reset <= 1'b0;
    @(posedge i_clock);
    test_reset();
    test_config();
    test_power();
    test_fault();
    give_verdict();
  end
endmodule : tb

`default_nettype wire
